// ### src/clock_config_pkg.sv
// shared constants and carrier types of the serial configuration port
package clock_config_pkg;

	// register space and address stepping
	localparam int ADDR_W = 10;
	localparam int REG_COUNT = 32'h233;
	localparam logic [ADDR_W-1:0] ADDR_FIRST = 10'h000;
	localparam logic [ADDR_W-1:0] ADDR_LAST = 10'h232;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 10'h001;
	localparam logic [ADDR_W-1:0] ADDR_PORT_CFG = 10'h000;
	localparam logic [ADDR_W-1:0] ADDR_READBACK = 10'h004;
	localparam logic [ADDR_W-1:0] ADDR_PLL = 10'h010;
	localparam logic [ADDR_W-1:0] ADDR_OUT_PD0 = 10'h0f0;
	localparam logic [ADDR_W-1:0] ADDR_DIST = 10'h230;
	localparam logic [ADDR_W-1:0] ADDR_UPDATE = 10'h232;

	// field positions
	localparam int BIT_SPLIT_OUT = 0;
	localparam int BIT_LSB_LO = 1;
	localparam int BIT_RESET_LO = 2;
	localparam int BIT_RESET_HI = 5;
	localparam int BIT_LSB_HI = 6;
	localparam int BIT_RDSEL = 0;
	localparam int BIT_DIST_PD = 1;
	localparam int BIT_UPDATE = 0;

	// reset values
	localparam logic [7:0] PORT_CFG_DEFAULT = 8'h18;
	localparam logic [7:0] LONG_INST_MASK = 8'h18;
	localparam logic [7:0] REG_DEFAULT = 8'h00;

	// pll and output power-down encodings
	localparam logic [1:0] PLL_NORMAL = 2'h0;
	localparam logic [1:0] PLL_ASYNC_PD = 2'h1;
	localparam logic [1:0] PLL_SYNC_PD = 2'h3;
	localparam logic [1:0] OUT_NORMAL = 2'h0;
	localparam logic [1:0] OUT_SAFE_PD = 2'h2;
	localparam logic [1:0] OUT_TOTAL_PD = 2'h3;

	// instruction word layout and counters
	localparam int INST_RW = 15;
	localparam int LEN_HI = 14;
	localparam int LEN_LO = 13;
	localparam int ADDR_TOP_HI = 12;
	localparam int ADDR_TOP_LO = 10;
	localparam logic [2:0] ADDR_TOP_ZERO = 3'h0;
	localparam logic [1:0] LEN_STREAM = 2'h3;
	localparam logic [3:0] INST_LAST_BIT = 4'hf;
	localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
	localparam logic [3:0] BIT_STEP = 4'h1;
	localparam logic [1:0] BYTE_STEP = 2'h1;

	// serial engine states
	typedef enum logic [1:0] {
		st_inst,
		st_data,
		st_done
	} xfer_e;

	// analog power controls driven by the port
	typedef struct packed {
		logic pll_off;
		logic vco_off;
		logic clk_buffer_off;
		logic dividers_off;
		logic dist_bias_off;
	} power_s;

endpackage

// ### src/config_register_bank.sv
// shadow buffer and active registers of the configuration space
`timescale 1ns/1ns
module config_register_bank import clock_config_pkg::*; #(
	parameter int NUM_OUTPUTS = 6
) (
	// system
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// control from the serial engine
	input wire logic soft_reset,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic update,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [7:0] rd_data,
	// active settings
	output logic [1:0] pll_mode,
	output logic dist_pd,
	output logic [NUM_OUTPUTS-1:0][1:0] out_mode
);

	logic [7:0] shadow [0:REG_COUNT-1];
	logic [7:0] active [0:REG_COUNT-1];
	logic wr_ok;

	// writes outside the space, to the port byte or the update byte are dropped
	assign wr_ok = wr_en && (wr_addr <= ADDR_LAST) && (wr_addr != ADDR_PORT_CFG)
		&& (wr_addr != ADDR_UPDATE);

	// soft reset holds everything at defaults until it is released
	always_ff @(posedge clock) begin
		if (rst || (ce && soft_reset)) begin
			for (int a = 0; a < REG_COUNT; a++) begin
				shadow[a] <= REG_DEFAULT;
				active[a] <= REG_DEFAULT;
			end
		end else if (ce) begin
			if (update) begin
				active <= shadow;
			end
			if (wr_ok) begin
				shadow[wr_addr] <= wr_data;
			end
		end
	end

	// readback source chosen by the active select bit
	always_comb begin
		rd_data = 8'h00;
		if (rd_addr <= ADDR_LAST) begin
			rd_data = active[ADDR_READBACK][BIT_RDSEL] ? active[rd_addr] : shadow[rd_addr];
		end
	end

	// active settings steering the analog sections
	assign pll_mode = active[ADDR_PLL][1:0];
	assign dist_pd = active[ADDR_DIST][BIT_DIST_PD];
	for (genvar i = 0; i < NUM_OUTPUTS; i++) begin : g_out
		assign out_mode[i] = active[ADDR_OUT_PD0 + ADDR_W'(i)][1:0];
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_update_copy: assert property (ce && update && !soft_reset |=>
		active[ADDR_DIST] == $past(shadow[ADDR_DIST]))
		else $error("update did not copy the buffer");
	a_soft_defaults: assert property (ce && soft_reset |=>
		shadow[ADDR_PLL] == REG_DEFAULT && active[ADDR_PLL] == REG_DEFAULT)
		else $error("soft reset left a register off default");

endmodule

// ### src/serial_config_port_reset_powerdown.sv
// serial configuration port with soft reset and power-down control
// Notes on behaviour
// - both reset bits set restores register defaults
// - reset holds until host writes either bit zero
// - soft reset acts at once, no update
// - power-down pin low stops analog, port stays
// - pin release resumes with current register values
// - pll mode: async at update, sync at pump
// - distribution power-down bit removes distribution bias
// - per-output power modes normal, safe, total
// - chip select high releases both data pins
// - sample on rising edge, launch on falling
// - split output bit moves readback to separate pin
// - sixteen-bit instruction precedes data bytes
// - length gives one to three bytes or stream
// - chip select high on byte boundary stalls, except in stream where it ends
// - chip select off boundary flushes and resets
// - stream steps address until the byte at the last address or until chip select rises
// - every address visited, unused writes ignored
// - writes buffered, update copies all at once
// - select bit picks buffer or active readback
// - instruction format bits always read ones
// - space spans first through last address
// - instruction: direction, length, thirteen-bit address
// - length codes one, two, three, stream
// - msb-first decrements, lsb-first increments, stream stops
// - lsb-first bits act at once
`timescale 1ns/1ns
module serial_config_port_reset_powerdown import clock_config_pkg::*; #(
	parameter int NUM_OUTPUTS = 6
) (
	// system
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// serial link pins
	input wire logic chip_select_n,
	input wire logic shift_clock,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_oe,
	output logic readback_output_pin,
	output logic readback_output_pin_oe,
	// device pins
	input wire logic power_down_pin_n,
	input wire logic charge_pump_event,
	// power controls
	output power_s power,
	output logic [NUM_OUTPUTS-1:0][1:0] out_pd_mode,
	// port status
	output logic soft_reset_active,
	output logic lsb_first_active
);

	// refuse output counts the register space cannot hold
	if (NUM_OUTPUTS < 1 || NUM_OUTPUTS > 16) begin : g_bad_outputs
		$error("NUM_OUTPUTS must lie between 1 and 16");
	end

	typedef struct packed {
		logic [2:0] cs_sync;
		logic [2:0] sclk_sync;
		logic [1:0] sdi_sync;
		logic [1:0] pdn_sync;
		logic [2:0] cp_sync;
		xfer_e state;
		logic [15:0] shift;
		logic [3:0] bit_cnt;
		logic rw;
		logic [1:0] len;
		logic [1:0] bytes_done;
		logic [ADDR_W-1:0] addr;
		logic [7:0] tx;
		logic rd_bit;
		logic [7:0] port_cfg;
		logic pll_down;
		power_s pwr;
		logic [NUM_OUTPUTS-1:0][1:0] out_mode;
	} state_s;

	state_s s;
	state_s next_s;

	logic cs_low;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic sdi;
	logic pdn;
	logic cp_rise;
	logic lsb_first;
	logic soft_reset;
	logic split_out;
	logic rd_phase;
	logic wr_en;
	logic [7:0] wr_data;
	logic update;
	logic [7:0] bank_rd;
	logic [7:0] rd_value;
	logic [1:0] pll_mode;
	logic dist_pd;
	logic [NUM_OUTPUTS-1:0][1:0] bank_out_mode;

	// shadow and active registers
	config_register_bank #(
		.NUM_OUTPUTS(NUM_OUTPUTS)
	) bank (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.soft_reset(soft_reset),
		.wr_en(wr_en),
		.wr_addr(s.addr),
		.wr_data(wr_data),
		.update(update),
		.rd_addr(s.addr),
		.rd_data(bank_rd),
		.pll_mode(pll_mode),
		.dist_pd(dist_pd),
		.out_mode(bank_out_mode)
	);

	// synchronised pins and their edges, read from the second flop onward
	assign cs_low = !s.cs_sync[1];
	assign cs_rise = s.cs_sync[1] && !s.cs_sync[2];
	assign sclk_rise = cs_low && s.sclk_sync[1] && !s.sclk_sync[2];
	assign sclk_fall = cs_low && !s.sclk_sync[1] && s.sclk_sync[2];
	assign sdi = s.sdi_sync[1];
	assign pdn = s.pdn_sync[1];
	assign cp_rise = s.cp_sync[1] && !s.cp_sync[2];

	// port byte acts on the port directly, bypassing the update
	assign lsb_first = s.port_cfg[BIT_LSB_LO] && s.port_cfg[BIT_LSB_HI];
	assign soft_reset = s.port_cfg[BIT_RESET_LO] && s.port_cfg[BIT_RESET_HI];
	assign split_out = s.port_cfg[BIT_SPLIT_OUT];

	// the port byte is held here, the rest in the bank
	assign rd_value = (s.addr == ADDR_PORT_CFG) ? s.port_cfg : bank_rd;

	// pin drive only during read data with chip select low
	assign rd_phase = cs_low && s.state == st_data && s.rw;
	assign serial_data_oe = rd_phase && !split_out;
	assign readback_output_pin_oe = rd_phase && split_out;
	assign serial_data_out = s.rd_bit;
	assign readback_output_pin = s.rd_bit;

	assign power = s.pwr;
	assign out_pd_mode = s.out_mode;
	assign soft_reset_active = soft_reset;
	assign lsb_first_active = lsb_first;

	// next state: synchronisers, serial engine, power controls
	always_comb begin
		logic [15:0] shifted;
		logic [7:0] in_byte;
		logic [7:0] cur;
		logic [ADDR_W-1:0] stepped;
		logic last_byte;
		shifted = '0;
		in_byte = '0;
		cur = '0;
		stepped = '0;
		last_byte = 1'b0;
		next_s = s;
		wr_en = 1'b0;
		wr_data = '0;
		update = 1'b0;

		next_s.cs_sync = {s.cs_sync[1:0], chip_select_n};
		next_s.sclk_sync = {s.sclk_sync[1:0], shift_clock};
		next_s.sdi_sync = {s.sdi_sync[0], serial_data_in};
		next_s.pdn_sync = {s.pdn_sync[0], power_down_pin_n};
		next_s.cp_sync = {s.cp_sync[1:0], charge_pump_event};

		// shift order follows the lsb-first setting
		shifted = lsb_first ? {sdi, s.shift[15:1]} : {s.shift[14:0], sdi};
		in_byte = lsb_first ? shifted[15:8] : shifted[7:0];
		if (lsb_first) begin
			stepped = (s.addr == ADDR_LAST) ? ADDR_FIRST : s.addr + ADDR_STEP;
		end else begin
			stepped = (s.addr == ADDR_FIRST) ? ADDR_LAST : s.addr - ADDR_STEP;
		end
		if (s.len == LEN_STREAM) begin
			last_byte = (s.addr == ADDR_LAST);
		end else begin
			last_byte = (s.bytes_done == s.len);
		end

		if (cs_rise) begin
			// mid-byte rise flushes, boundary rise stalls or ends
			if (s.bit_cnt[2:0] != 3'h0 || s.state == st_done
					|| (s.state == st_data && s.len == LEN_STREAM)) begin
				next_s.state = st_inst;
				next_s.bit_cnt = '0;
				next_s.shift = '0;
			end
		end else if (sclk_rise) begin
			unique case (s.state)
				st_inst: begin
					next_s.shift = shifted;
					next_s.bit_cnt = s.bit_cnt + BIT_STEP;
					if (s.bit_cnt == INST_LAST_BIT) begin
						next_s.rw = shifted[INST_RW];
						next_s.len = shifted[LEN_HI:LEN_LO];
						next_s.addr = shifted[ADDR_W-1:0];
						next_s.bytes_done = '0;
						next_s.bit_cnt = '0;
						// nonzero upper address bits void the transfer
						if (shifted[ADDR_TOP_HI:ADDR_TOP_LO] == ADDR_TOP_ZERO) begin
							next_s.state = st_data;
						end else begin
							next_s.state = st_done;
						end
					end
				end
				st_data: begin
					next_s.shift = shifted;
					next_s.bit_cnt = s.bit_cnt + BIT_STEP;
					if (s.bit_cnt == BYTE_LAST_BIT) begin
						next_s.bit_cnt = '0;
						if (!s.rw) begin
							if (s.addr == ADDR_PORT_CFG) begin
								next_s.port_cfg = in_byte | LONG_INST_MASK;
							end else if (s.addr == ADDR_UPDATE) begin
								update = in_byte[BIT_UPDATE];
							end else begin
								wr_en = 1'b1;
								wr_data = in_byte;
							end
						end
						next_s.addr = stepped;
						next_s.bytes_done = s.bytes_done + BYTE_STEP;
						if (last_byte) begin
							next_s.state = st_done;
						end
					end
				end
				st_done: begin
				end
			endcase
		end else if (sclk_fall && s.state == st_data && s.rw) begin
			// launch readback, fetching a fresh byte at each boundary
			cur = (s.bit_cnt == 4'h0) ? rd_value : s.tx;
			next_s.rd_bit = lsb_first ? cur[0] : cur[7];
			next_s.tx = lsb_first ? {1'b0, cur[7:1]} : {cur[6:0], 1'b0};
		end

		// pll power-down follows the active mode
		case (pll_mode)
			PLL_ASYNC_PD: next_s.pll_down = 1'b1;
			PLL_SYNC_PD: next_s.pll_down = s.pll_down || cp_rise;
			default: next_s.pll_down = 1'b0;
		endcase

		// power pin overrides, registers resume on release
		next_s.pwr.pll_off = next_s.pll_down || !pdn;
		next_s.pwr.vco_off = !pdn;
		next_s.pwr.clk_buffer_off = !pdn;
		next_s.pwr.dividers_off = !pdn;
		next_s.pwr.dist_bias_off = dist_pd || !pdn;
		for (int i = 0; i < NUM_OUTPUTS; i++) begin
			next_s.out_mode[i] = pdn ? bank_out_mode[i] : OUT_SAFE_PD;
		end
	end

	// state register with clock enable and synchronous reset
	always_ff @(posedge clock) begin
		if (rst) begin
			s <= '0;
			s.cs_sync <= 3'h7;
			s.pdn_sync <= 2'h3;
			s.port_cfg <= PORT_CFG_DEFAULT;
			s.state <= st_inst;
		end else if (ce) begin
			s <= next_s;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_idle_release: assert property (!cs_low |-> !serial_data_oe && !readback_output_pin_oe)
		else $error("data pin driven with chip select high");
	a_write_release: assert property (cs_low && s.state != st_data |-> !serial_data_oe)
		else $error("shared pin driven outside read data");
	a_split_route: assert property (rd_phase && split_out |-> readback_output_pin_oe && !serial_data_oe)
		else $error("readback not moved to the separate pin");
	a_pin_powerdown: assert property (ce && !pdn |=> s.pwr.pll_off && s.pwr.vco_off
		&& s.pwr.dividers_off && s.pwr.clk_buffer_off && s.out_mode[0] == OUT_SAFE_PD)
		else $error("power pin low left a section running");
	a_pll_async: assert property (ce && pll_mode == PLL_ASYNC_PD |=> s.pwr.pll_off)
		else $error("async pll power-down did not act");
	a_pll_sync_wait: assert property (ce && pll_mode == PLL_SYNC_PD && !s.pll_down && !cp_rise
		|=> !s.pll_down)
		else $error("sync pll power-down did not wait for a pump event");
	a_dist_bias: assert property (ce && dist_pd |=> s.pwr.dist_bias_off)
		else $error("distribution bias left on");
	a_flush_partial: assert property (ce && cs_rise && s.bit_cnt[2:0] != 3'h0
		|=> s.state == st_inst && s.bit_cnt == 4'h0)
		else $error("partial byte not flushed");
	a_stall_hold: assert property (ce && cs_rise && s.bit_cnt[2:0] == 3'h0 && s.state == st_data
		&& s.len != LEN_STREAM |=> s.state == st_data && $stable(s.addr))
		else $error("stall lost the transfer");
	a_format_bits: assert property (s.port_cfg[4:3] == 2'h3)
		else $error("instruction format bits not ones");


	// serial engine sequencing checks
	// a byte lands in the bank only at its last write rise
	a_write_commit: assert property (wr_en |-> s.bit_cnt == BYTE_LAST_BIT && !s.rw
		&& s.addr != ADDR_PORT_CFG && s.addr != ADDR_UPDATE)
		else $error("write strobe outside a byte end");
	// the update pulse comes only from a write of the update byte
	a_update_pulse: assert property (update |-> s.state == st_data
		&& s.addr == ADDR_UPDATE && !s.rw)
		else $error("update pulse without an update write");
	// once the byte count is reached nothing more is written
	a_done_ignores: assert property (s.state == st_done |->
		!wr_en && !update)
		else $error("write after the last byte");
	// msb-first transfers step downward
	a_msb_step: assert property (ce && wr_en && !lsb_first && s.addr != ADDR_FIRST |->
		##1 s.addr == $past(s.addr) - ADDR_STEP)
		else $error("msb-first address did not decrement");
	// lsb-first transfers step upward
	a_lsb_step: assert property (ce && wr_en && lsb_first && s.addr != ADDR_LAST |->
		##1 s.addr == $past(s.addr) + ADDR_STEP)
		else $error("lsb-first address did not increment");
	// a stream ends after the byte at the last address
	a_stream_stop: assert property (ce && sclk_rise && s.state == st_data && s.len == LEN_STREAM
		&& s.addr == ADDR_LAST && s.bit_cnt == BYTE_LAST_BIT |=> s.state == st_done)
		else $error("stream ran past the last address");
	// first read bit of a byte is its top bit in msb-first order
	a_read_launch: assert property (ce && sclk_fall && s.state == st_data && s.rw
		&& s.bit_cnt == 4'h0 && !lsb_first |=> s.rd_bit == $past(rd_value[7]))
		else $error("read byte launched in the wrong order");
	// pin high hands the active modes straight to the outputs
	a_pin_resume: assert property (ce && pdn |->
		##1 s.out_mode == $past(bank_out_mode))
		else $error("outputs did not resume the register modes");

	c_write_byte: cover property (wr_en && ce);
	c_stream_end: cover property (s.state == st_data && s.len == LEN_STREAM && s.addr == ADDR_LAST);
	c_read_phase: cover property (rd_phase && sclk_fall);
	c_update: cover property (update && ce);
	c_stall: cover property (cs_rise && s.state == st_data && s.bit_cnt == 4'h0);

endmodule

// ### verification/host_master_model.sv
// behavioural host that drives frames over the serial configuration link
`timescale 1ns/1ns
module host_master_model (
	// system
	input wire logic clock,
	// serial link
	output logic chip_select_n,
	output logic shift_clock,
	output logic drv_bit,
	output logic drv_en,
	input wire logic line
);
	// idle link: deselected, shift clock parked low
	initial begin
		chip_select_n = 1'b1;
		shift_clock = 1'b0;
		drv_bit = 1'b0;
		drv_en = 1'b0;
	end

	// instruction first, then data; each clock phase lasts four system clocks
	task automatic frame(input logic [39:0] v, input int nbits, input int stall_at,
		output logic [23:0] rd);
		int i;
		rd = '0;
		@(posedge clock);
		chip_select_n <= 1'b0; // every access opens with select low
		for (i = 0; i < nbits; i++) begin
			if (i == stall_at) begin
				chip_select_n <= 1'b1; // pause only on a byte boundary
				repeat (8) @(posedge clock);
				chip_select_n <= 1'b0;
			end
			drv_en <= (i < 16) || !v[39]; // release the pin for read data
			drv_bit <= v[39-i];
			repeat (4) @(posedge clock);
			shift_clock <= 1'b1; // data valid before the rise
			if (i >= 16) begin
				rd = {rd[22:0], line}; // readback launched on the fall before
			end
			repeat (4) @(posedge clock);
			shift_clock <= 1'b0;
		end
		repeat (4) @(posedge clock);
		chip_select_n <= 1'b1; // raising select ends the frame
		drv_en <= 1'b0;
		repeat (8) @(posedge clock);
	endtask
endmodule

// ### verification/tb_serial_config_port_reset_powerdown.sv
// self-checking bench of the serial configuration port
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("BAD %s expected %h seen %h", nm, e, g); end end
module tb_serial_config_port_reset_powerdown import clock_config_pkg::*; ();
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic power_down_pin_n = 1'b1;
	logic charge_pump_event = 1'b0;
	logic chip_select_n, shift_clock, drv_bit, drv_en, sdio, host_line;
	logic serial_data_out, serial_data_oe, readback_output_pin, readback_output_pin_oe;
	logic soft_reset_active, lsb_first_active;
	power_s power;
	logic [5:0][1:0] out_pd_mode;
	logic [23:0] r;
	int fail_count = 0;
	int n_tests = 0;
	int oe_cycles = 0;
	int oe_base = 0;
	logic ce = 1'b1;

	// shared pin level: device, host, else the inverse of the host's last bit
	assign sdio = serial_data_oe ? serial_data_out : (drv_en ? drv_bit : ~drv_bit);
	assign host_line = readback_output_pin_oe ? readback_output_pin : sdio;

	// clock
	initial begin
		forever #50 clock = ~clock;
	end

	// count cycles in which the shared pin is driven
	always @(posedge clock) begin
		if (serial_data_oe === 1'b1) oe_cycles <= oe_cycles + 1;
	end

	serial_config_port_reset_powerdown #(.NUM_OUTPUTS(6)) i_serial_config_port_reset_powerdown (
		.clock(clock), .rst(rst), .ce(ce),
		.chip_select_n(chip_select_n), .shift_clock(shift_clock), .serial_data_in(sdio),
		.serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
		.readback_output_pin(readback_output_pin),
		.readback_output_pin_oe(readback_output_pin_oe),
		.power_down_pin_n(power_down_pin_n), .charge_pump_event(charge_pump_event),
		.power(power), .out_pd_mode(out_pd_mode),
		.soft_reset_active(soft_reset_active), .lsb_first_active(lsb_first_active)
	);

	host_master_model i_host_master_model (
		.clock(clock), .chip_select_n(chip_select_n), .shift_clock(shift_clock),
		.drv_bit(drv_bit), .drv_en(drv_en), .line(host_line)
	);

	// single-byte write and read, and the update command
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		i_host_master_model.frame({1'b0, 2'h0, 3'h0, a, d, 16'h0000}, 24, -1, r);
	endtask
	task automatic rd1(input logic [ADDR_W-1:0] a);
		i_host_master_model.frame({1'b1, 2'h0, 3'h0, a, 24'h000000}, 24, -1, r);
	endtask
	task automatic upd;
		wr(ADDR_UPDATE, 8'h01);
	endtask

	task automatic t_defaults;
		`CHK("power", 5'h00, power)
		`CHK("modes", 12'h000, out_pd_mode)
		`CHK("softrst", 1'b0, soft_reset_active)
		i_host_master_model.frame({1'b1, LEN_STREAM, 3'h0, 10'h001, 24'h0}, 40, -1, r);
		`CHK("stream wrap", 24'h001800, r)
		`CHK("oe idle", 1'b0, serial_data_oe)
	endtask

	task automatic t_shadow;
		wr(ADDR_OUT_PD0, {6'h00, OUT_SAFE_PD});
		`CHK("buffered", 2'h0, out_pd_mode[0])
		rd1(ADDR_OUT_PD0);
		`CHK("read buffer", 24'h000002, r)
		wr(ADDR_READBACK, 8'h01);
		upd();
		`CHK("safe mode", OUT_SAFE_PD, out_pd_mode[0])
		wr(ADDR_OUT_PD0, {6'h00, OUT_TOTAL_PD});
		rd1(ADDR_OUT_PD0);
		`CHK("read active", 24'h000002, r)
		wr(ADDR_READBACK, 8'h00);
		upd();
		`CHK("total mode", OUT_TOTAL_PD, out_pd_mode[0])
	endtask

	task automatic t_multi_abort;
		i_host_master_model.frame({1'b0, 2'h2, 3'h0, 10'h0f3, 24'h030200}, 40, 16, r);
		upd();
		`CHK("three bytes", 12'h0e3, out_pd_mode)
		i_host_master_model.frame({1'b0, 2'h0, 3'h0, ADDR_OUT_PD0, 24'h0}, 20, -1, r);
		upd();
		`CHK("flushed", 12'h0e3, out_pd_mode)
	endtask

	task automatic t_power;
		wr(ADDR_DIST, 8'h02);
		upd();
		`CHK("dist bias", 1'b1, power.dist_bias_off)
		wr(ADDR_DIST, 8'h00);
		wr(ADDR_PLL, {6'h00, PLL_ASYNC_PD});
		upd();
		`CHK("pll async", 5'h10, power)
		wr(ADDR_PLL, {6'h00, PLL_SYNC_PD});
		upd();
		`CHK("pll on after sync", 1'b1, power.pll_off)
		wr(ADDR_PLL, 8'h00);
		upd();
		wr(ADDR_PLL, {6'h00, PLL_SYNC_PD});
		upd();
		`CHK("pll waits pump", 1'b0, power.pll_off)
		@(posedge clock) charge_pump_event <= 1'b1;
		repeat (4) @(posedge clock);
		charge_pump_event <= 1'b0;
		repeat (8) @(posedge clock);
		`CHK("pll at pump", 1'b1, power.pll_off)
		wr(ADDR_PLL, 8'h00);
		upd();
	endtask

	task automatic t_pin;
		@(posedge clock) ce <= 1'b0;
		power_down_pin_n <= 1'b0;
		repeat (8) @(posedge clock);
		`CHK("frozen modes", 12'h0e3, out_pd_mode)
		`CHK("frozen power", 5'h00, power)
		ce <= 1'b1;
		repeat (8) @(posedge clock);
		`CHK("pin off", 4'hf, power[4:1])
		`CHK("pin safe", 12'haaa, out_pd_mode)
		wr(ADDR_OUT_PD0, 8'h00);
		upd();
		rd1(ADDR_OUT_PD0);
		`CHK("port alive", 24'h000000, r)
		@(posedge clock) power_down_pin_n <= 1'b1;
		repeat (8) @(posedge clock);
		`CHK("resume", 12'h0e0, out_pd_mode)
		`CHK("resume power", 5'h00, power)
	endtask

	task automatic t_soft_split;
		wr(ADDR_PORT_CFG, 8'h3c);
		`CHK("soft on", 1'b1, soft_reset_active)
		`CHK("defaults", 12'h000, out_pd_mode)
		wr(ADDR_PORT_CFG, 8'h18);
		`CHK("soft off", 1'b0, soft_reset_active)
		wr(ADDR_OUT_PD0, 8'h02);
		wr(ADDR_PORT_CFG, 8'h99);
		oe_base = oe_cycles;
		rd1(ADDR_OUT_PD0);
		`CHK("split read", 24'h000002, r)
		`CHK("pin quiet", 0, oe_cycles - oe_base)
		wr(ADDR_PORT_CFG, 8'h18);
		rd1(ADDR_OUT_PD0);
		`CHK("shared read", 24'h000002, r)
		`CHK("pin driven", 1'b1, (oe_cycles - oe_base) > 0)
		wr(ADDR_PORT_CFG, 8'h5a);
		`CHK("lsb now", 1'b1, lsb_first_active)
		// read of the port byte with the instruction sent lsb first
		i_host_master_model.frame({16'h0001, 24'h000000}, 24, -1, r);
		`CHK("lsb read", 24'h00005a, r)
	endtask

	// verdict and end of run
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		repeat (6) @(posedge clock);
		t_defaults();
		t_shadow();
		t_multi_abort();
		t_power();
		t_pin();
		t_soft_split();
		conclude();
	end

	// watchdog
	initial begin
		#5000000;
		fail_count++;
		conclude();
	end
endmodule
